/* File: rtl/swd_defines.svh */
`ifndef SWD_DEFINES_SVH
`define SWD_DEFINES_SVH
`define SWD_AW       8
`define SWD_CTRL_OFF 8'h00
`define SWD_STAT_OFF 8'h04
`define SWD_EN_BIT   0
`define SWD_ACK_CYC  8'h10
`define SWD_LACK_CYC 8'h20
`define SWD_SYNC_CYC 8'h80
`define SWD_RDLY_CYC 8'h10
`define SWD_CNT_MAX  8'hFF
`define SWD_RESP_OK  2'h0
`define SWD_RESP_ERR 2'h2
`endif

/* File: rtl/swd_pkg.sv */
`default_nettype none
package swd_pkg;
    typedef enum logic [2:0] {
        SWD_K_ACKEN = 3'h0,
        SWD_K_BKGND = 3'h1,
        SWD_K_GO    = 3'h2,
        SWD_K_NONI  = 3'h3,
        SWD_K_INTR  = 3'h4
    } swd_kind_t;
    typedef struct packed {
        logic      valid;
        swd_kind_t kind;
    } swd_cmd_t;
    typedef struct packed {
        logic insn_done;
        logic in_wait;
        logic in_stop;
    } swd_cpu_t;
    typedef struct packed {
        logic pend;
        logic ack_en;
        logic wait_f;
        logic no_resp;
        logic act;
    } swd_stat_t;
    typedef enum logic [6:0] {
        SWD_S_IDLE = 7'h01,
        SWD_S_EXEC = 7'h02,
        SWD_S_ACKL = 7'h04,
        SWD_S_ACKH = 7'h08,
        SWD_S_SYNW = 7'h10,
        SWD_S_SYNL = 7'h20,
        SWD_S_SYNH = 7'h40
    } swd_state_t;
endpackage
`default_nettype wire

/* File: rtl/swd_handshake.sv */
// Notes on behaviour
// RQ1 - Acknowledge enable handled here, core untouched
// RQ2 - Acknowledge enable always answers with pulse
// RQ3 - Later handshake commands acknowledged after execution
// RQ4 - Halt enters debug after current instruction
// RQ5 - Halt ignored while debug disabled
// RQ6 - Host waits 16 clocks after halt
// RQ7 - Host sets debug enable before halt
// RQ8 - Halt in wait or stop stays pending
// RQ9 - Pending low power: no-response, wait set
// RQ10 - Non-halting commands still run in wait
// RQ11 - First acknowledge after low power long; code does so only if debug was enabled when low power began
// RQ12 - Host abort: 128 low, one high
// RQ13 - Long low cancels command and acknowledge
// RQ14 - Host waits for resync to finish
// RQ15 - Host abort pulse slightly over 128
// RQ16 - Acknowledge and abort collision not prevented
// RQ17 - Reset clears acknowledge enable
// RQ18 - Pin driven high only for speedup
`include "swd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module swd_handshake
    import swd_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Register bus write
    input  wire logic [`SWD_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // Register bus read
    input  wire logic [`SWD_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Debug pin
    input  wire logic              debug_pin_i,
    output logic                   debug_pin_o,
    output logic                   debug_pin_oe,
    // Decoded commands
    input  wire swd_cmd_t          cmd_i,
    input  wire logic              exec_done_i,
    output logic                   exec_start_o,
    output logic                   exec_abort_o,
    // Processor side
    input  wire swd_cpu_t          cpu_i,
    output logic                   halt_req_o,
    output logic                   debug_active_o
);
    function automatic logic hit(
        input logic [`SWD_AW-1:0] a,
        input logic [`SWD_AW-1:0] off
    );
        hit = (a[`SWD_AW-1:2] == off[`SWD_AW-1:2]);
    endfunction

    function automatic logic [7:0] ld(input logic [7:0] n);
        ld = n - 8'h01;
    endfunction

    // ****************************************
    // Register bus slave
    // ****************************************
    logic        awready_q;
    logic        wready_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        arready_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;
    logic        en_q;
    swd_stat_t   stat_q;

    wire aw_go   = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
    wire ar_go   = s_axi_arvalid & ~arready_q & ~rvalid_q;
    wire w_ctrl  = hit(s_axi_awaddr, `SWD_CTRL_OFF);
    wire w_ok    = w_ctrl | hit(s_axi_awaddr, `SWD_STAT_OFF);
    wire r_ctrl  = hit(s_axi_araddr, `SWD_CTRL_OFF);
    wire r_stat  = hit(s_axi_araddr, `SWD_STAT_OFF);
    wire en_wr   = awready_q & w_ctrl & s_axi_wstrb[0];
    wire [31:0] rd_word = r_ctrl ? {31'h0, en_q} :
                          r_stat ? {27'h0, stat_q} : 32'h0;

    // Address and data are taken together, one cycle after both are offered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `SWD_RESP_OK;
            en_q      <= 1'b0;
        end else begin
            awready_q <= aw_go;
            wready_q  <= aw_go;
            if (awready_q) begin
                bvalid_q <= 1'b1;
                bresp_q  <= w_ok ? `SWD_RESP_OK : `SWD_RESP_ERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (en_wr) begin
                en_q <= s_axi_wdata[`SWD_EN_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= `SWD_RESP_OK;
            rdata_q   <= 32'h0;
        end else begin
            arready_q <= ar_go;
            if (arready_q) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= (r_ctrl | r_stat) ? `SWD_RESP_OK : `SWD_RESP_ERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // ****************************************
    // Pin sampling and abort detection
    // ****************************************
    logic       pin_s1_q;
    logic       pin_s2_q;
    logic       pin_o_q;
    logic       pin_oe_q;
    logic [7:0] lowcnt_q;

    // Own drive is masked, so an abort that overlaps our pulse goes unseen
    wire       pin_low  = ~pin_s2_q & ~pin_oe_q;
    wire       low_sat  = (lowcnt_q == `SWD_CNT_MAX);
    wire [7:0] lowcnt_d = !pin_low ? 8'h00 :
                          low_sat  ? lowcnt_q : 8'(lowcnt_q + 8'h01);
    wire       sync_det = pin_s2_q & ~pin_oe_q
                        & (lowcnt_q >= `SWD_SYNC_CYC); // see RQ13 see RQ16

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            lowcnt_q <= 8'h00;
        end else begin
            pin_s1_q <= debug_pin_i;
            pin_s2_q <= pin_s1_q;
            lowcnt_q <= lowcnt_d;
        end
    end

    // ****************************************
    // Command handshake state machine
    // ****************************************
    swd_state_t st_q;
    swd_state_t st_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       ack_en_q;
    logic       pend_q;
    logic       act_q;
    logic       lp_q;
    logic       lp_seen_q;
    logic       exec_q;
    logic       abort_q;
    logic       ackon;
    logic       pend_set;
    logic       act_clr;
    logic       ex_d;
    logic       ack_go;

    wire lp      = cpu_i.in_wait | cpu_i.in_stop;
    wire enter   = pend_q & cpu_i.insn_done & ~lp; // see RQ4 see RQ8
    wire lp_rise = lp & ~lp_q & en_q;
    wire abort_d = sync_det & (st_q == SWD_S_EXEC);

    always_comb begin
        st_d     = st_q;
        cnt_d    = (cnt_q != 8'h00) ? ld(cnt_q) : cnt_q;
        ackon    = 1'b0;
        pend_set = 1'b0;
        act_clr  = 1'b0;
        ex_d     = 1'b0;
        ack_go   = 1'b0;
        case (st_q)
            SWD_S_IDLE: begin
                if (sync_det) begin
                    st_d  = SWD_S_SYNW;
                    cnt_d = ld(`SWD_RDLY_CYC);
                end else if (cmd_i.valid) begin
                    case (cmd_i.kind)
                        SWD_K_ACKEN: begin
                            ackon  = 1'b1; // see RQ1
                            ack_go = 1'b1; // see RQ2
                        end
                        SWD_K_BKGND: begin
                            pend_set = en_q; // see RQ5
                            ack_go   = en_q & ack_en_q;
                        end
                        SWD_K_GO: begin
                            act_clr = act_q;
                            ack_go  = act_q & ack_en_q;
                        end
                        SWD_K_NONI: begin
                            st_d = SWD_S_EXEC; // see RQ10
                            ex_d = 1'b1;
                        end
                        SWD_K_INTR: begin
                            if (act_q) begin
                                st_d = SWD_S_EXEC;
                                ex_d = 1'b1;
                            end
                        end
                        default: begin
                            st_d = SWD_S_IDLE;
                        end
                    endcase
                end
            end
            SWD_S_EXEC: begin
                if (sync_det) begin
                    st_d  = SWD_S_SYNW; // see RQ13
                    cnt_d = ld(`SWD_RDLY_CYC);
                end else if (exec_done_i) begin
                    st_d   = SWD_S_IDLE;
                    ack_go = ack_en_q; // see RQ3
                end
            end
            SWD_S_ACKL: begin
                if (cnt_q == 8'h00) begin
                    st_d = SWD_S_ACKH;
                end
            end
            SWD_S_SYNW: begin
                if (cnt_q == 8'h00) begin
                    st_d  = SWD_S_SYNL;
                    cnt_d = ld(`SWD_SYNC_CYC);
                end
            end
            SWD_S_SYNL: begin
                if (cnt_q == 8'h00) begin
                    st_d = SWD_S_SYNH;
                end
            end
            SWD_S_ACKH,
            SWD_S_SYNH: begin
                st_d = SWD_S_IDLE;
            end
            default: begin
                st_d = SWD_S_IDLE;
            end
        endcase
        if (ack_go) begin
            st_d  = SWD_S_ACKL;
            cnt_d = lp_seen_q ? ld(`SWD_LACK_CYC)
                              : ld(`SWD_ACK_CYC); // see RQ11
        end
    end

    // Speedup is a single driven-high cycle; otherwise low or released
    wire oe_d = (st_d == SWD_S_ACKL) | (st_d == SWD_S_ACKH)
              | (st_d == SWD_S_SYNL) | (st_d == SWD_S_SYNH);
    wire po_d = (st_d == SWD_S_ACKH) | (st_d == SWD_S_SYNH); // see RQ18

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q     <= SWD_S_IDLE;
            cnt_q    <= 8'h00;
            pin_o_q  <= 1'b0;
            pin_oe_q <= 1'b0;
            exec_q   <= 1'b0;
            abort_q  <= 1'b0;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            pin_o_q  <= po_d;
            pin_oe_q <= oe_d;
            exec_q   <= ex_d;
            abort_q  <= abort_d;
        end
    end

    // ****************************************
    // Halt request, flags and status
    // ****************************************
    // Set wins over clear on every sticky flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_en_q  <= 1'b0; // see RQ17
            pend_q    <= 1'b0;
            act_q     <= 1'b0;
            lp_q      <= 1'b0;
            lp_seen_q <= 1'b0;
            stat_q    <= '0;
        end else begin
            ack_en_q  <= ack_en_q | ackon;
            pend_q    <= (pend_q & ~enter) | pend_set;
            act_q     <= (act_q & ~act_clr) | enter;
            lp_q      <= lp;
            lp_seen_q <= (lp_seen_q & ~ack_go) | lp_rise; // see RQ11
            stat_q.pend    <= pend_q;
            stat_q.ack_en  <= ack_en_q;
            stat_q.wait_f  <= lp;
            stat_q.no_resp <= pend_q & lp; // see RQ9
            stat_q.act     <= act_q;
        end
    end

    assign debug_pin_o    = pin_o_q;
    assign debug_pin_oe   = pin_oe_q;
    assign exec_start_o   = exec_q;
    assign exec_abort_o   = abort_q;
    assign halt_req_o     = pend_q;
    assign debug_active_o = act_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire idle_cmd = (st_q == SWD_S_IDLE) & cmd_i.valid & ~sync_det;

    a_ack_enable_ack: assert property ( // see RQ1 see RQ2
        idle_cmd && cmd_i.kind == SWD_K_ACKEN
        |=> debug_pin_oe && !debug_pin_o ##1 ack_en_q)
        else $error("ack enable not answered");
    a_exec_then_ack: assert property ( // see RQ3
        st_q == SWD_S_EXEC && exec_done_i && !sync_det && ack_en_q
        |=> st_q == SWD_S_ACKL && debug_pin_oe)
        else $error("executed command not acknowledged");
    a_halt_enter: assert property ( // see RQ4
        pend_q && cpu_i.insn_done && !lp |=> act_q && !pend_q)
        else $error("halt not taken at instruction end");
    a_halt_ignored: assert property ( // see RQ5
        idle_cmd && cmd_i.kind == SWD_K_BKGND && !en_q
        |=> pend_q == $past(pend_q) && st_q == SWD_S_IDLE)
        else $error("halt acted on while disabled");
    a_wait_pending: assert property ( // see RQ8
        pend_q && lp && !act_q |=> !act_q)
        else $error("debug entered during low power");
    a_no_response_flag_flags: assert property ( // see RQ9
        pend_q && lp && !act_q
        |=> stat_q.no_resp && stat_q.wait_f && !stat_q.act)
        else $error("pending status flags wrong");
    a_nonintr_wait: assert property ( // see RQ10
        idle_cmd && cmd_i.kind == SWD_K_NONI
        |=> st_q == SWD_S_EXEC && exec_start_o)
        else $error("non-halting command refused");
    a_long_ack: assert property ( // see RQ11
        ack_go && lp_seen_q && !lp_rise
        |=> st_q == SWD_S_ACKL && cnt_q == ld(`SWD_LACK_CYC) && !lp_seen_q)
        else $error("first ack after low power not long");
    a_sync_cancel: assert property ( // see RQ13
        sync_det && (st_q == SWD_S_EXEC || st_q == SWD_S_IDLE)
        |=> st_q == SWD_S_SYNW && !debug_pin_oe)
        else $error("abort not honoured");
    a_speedup_one: assert property ( // see RQ18
        debug_pin_oe && debug_pin_o |=> !debug_pin_oe)
        else $error("pin driven high longer than one cycle");
    a_reset_ack_off: assert property ( // see RQ17
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> !ack_en_q && !debug_pin_oe)
        else $error("reset left acknowledge enabled");
endmodule
`default_nettype wire

/* File: test/swd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module swd_host_model (
    // Clock
    input  wire logic aclk,
    // Device side of the pin
    input  wire logic dev_o,
    input  wire logic dev_oe,
    // Resolved pin level
    output logic      pin
);
    // ****************************************
    // Pin resolution
    // ****************************************
    logic host_o;
    logic host_oe;

    initial begin
        host_o  = 1'b1;
        host_oe = 1'b0;
    end

    // Pull-up holds the line high once both sides let go
    assign pin = dev_oe ? dev_o : (host_oe ? host_o : 1'b1);

    // ****************************************
    // Host actions
    // ****************************************
    // Long low then one speedup cycle; a little over the minimum for margin
    // No attempt to avoid a device speedup landing on top of it
    task automatic abort_req();
        begin
            @(posedge aclk);
            host_oe <= 1'b1;
            host_o  <= 1'b0;
            repeat (130) @(posedge aclk);
            host_o <= 1'b1;
            @(posedge aclk);
            host_oe <= 1'b0;
        end
    endtask

    // Measures the next device pulse: low cycles, then high speedup cycles
    // Callers wait on this before the next command after an abort
    task automatic catch_pulse(input int lim, output int n_low, output int n_hi);
        int t;
        begin
            n_low = 0;
            n_hi  = 0;
            t     = 0;
            @(negedge aclk);
            while (!(dev_oe && !dev_o) && t < lim) begin
                @(negedge aclk);
                t++;
            end
            while (dev_oe && !dev_o) begin
                n_low++;
                @(negedge aclk);
            end
            while (dev_oe && dev_o) begin
                n_hi++;
                @(negedge aclk);
            end
        end
    endtask
endmodule
`default_nettype wire

/* File: test/tb_swd_handshake.sv */
`include "swd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_swd_handshake
    import swd_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic pin, pin_o, pin_oe, exec_start, exec_abort, halt_req, dbg_act;
    logic exec_done = 1'b0;
    swd_cmd_t cmd = '0;
    swd_cpu_t cpu = '0;
    int n_fail = 0, n_checks = 0, n_start = 0, n_abort = 0, lo, hi;

    always #20 aclk = ~aclk;

    always @(posedge aclk) begin
        if (exec_start === 1'b1) n_start++;
        if (exec_abort === 1'b1) n_abort++;
    end

    swd_handshake i_swd_handshake (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .debug_pin_i(pin), .debug_pin_o(pin_o), .debug_pin_oe(pin_oe),
        .cmd_i(cmd), .exec_done_i(exec_done), .exec_start_o(exec_start),
        .exec_abort_o(exec_abort), .cpu_i(cpu), .halt_req_o(halt_req), .debug_active_o(dbg_act)
    );

    swd_host_model i_host (.aclk(aclk), .dev_o(pin_o), .dev_oe(pin_oe), .pin(pin));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w  = 1'b0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (awvalid && awready) begin aw = 1'b1; awvalid <= 1'b0; end
            if (wvalid && wready) begin w = 1'b1; wvalid <= 1'b0; end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        check("rresp", {30'h0, rresp}, {30'h0, er});
        check("rdata", rdata, ed);
    endtask

    task automatic send(input swd_kind_t k);
        @(posedge aclk);
        cmd <= '{valid: 1'b1, kind: k};
        @(posedge aclk);
        cmd <= '0;
    endtask

    task automatic pulse_done();
        @(posedge aclk); exec_done <= 1'b1;
        @(posedge aclk); exec_done <= 1'b0;
    endtask

    task automatic insn_end();
        @(posedge aclk); cpu.insn_done <= 1'b1;
        @(posedge aclk); cpu.insn_done <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic ack_is(input int n_exp);
        i_host.catch_pulse(200, lo, hi);
        check("ack_low", lo, n_exp);
        check("speedup", hi, (n_exp > 0) ? 1 : 0);
    endtask

    task automatic do_reset();
        @(posedge aclk); aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        #(40 * 10000);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        do_reset();
        rd(`SWD_STAT_OFF, 32'h0, `SWD_RESP_OK);
        rd(`SWD_CTRL_OFF, 32'h0, `SWD_RESP_OK);
        rd(8'h08, 32'h0, `SWD_RESP_ERR);
        wr(8'h08, 32'h1, `SWD_RESP_ERR);
        send(SWD_K_BKGND);
        ack_is(0);
        check("halt_off", {31'h0, halt_req}, 32'h0);
        send(SWD_K_ACKEN);
        ack_is(16);
        check("no_exec", n_start, 0);
        rd(`SWD_STAT_OFF, 32'h08, `SWD_RESP_OK);
        wr(`SWD_CTRL_OFF, 32'h1, `SWD_RESP_OK);
        rd(`SWD_CTRL_OFF, 32'h1, `SWD_RESP_OK);
        send(SWD_K_BKGND);
        ack_is(16);
        check("halt_req", {31'h0, halt_req}, 32'h1);
        insn_end();
        check("active", {31'h0, dbg_act}, 32'h1);
        check("halt_clr", {31'h0, halt_req}, 32'h0);
        rd(`SWD_STAT_OFF, 32'h09, `SWD_RESP_OK);
        repeat (16) @(posedge aclk);
        send(SWD_K_GO);
        ack_is(16);
        check("go", {31'h0, dbg_act}, 32'h0);
        // Halting command outside active debug is dropped without a trace
        send(SWD_K_INTR);
        ack_is(0);
        check("intr_off", n_start, 0);
        // Halt while asleep: first acknowledge after entry is long
        @(posedge aclk); cpu.in_wait <= 1'b1;
        repeat (4) @(posedge aclk);
        send(SWD_K_BKGND);
        ack_is(32);
        insn_end();
        check("wait_act", {31'h0, dbg_act}, 32'h0);
        check("wait_pend", {31'h0, halt_req}, 32'h1);
        rd(`SWD_STAT_OFF, 32'h1E, `SWD_RESP_OK);
        send(SWD_K_NONI);
        repeat (2) @(posedge aclk);
        check("wait_exec", n_start, 1);
        pulse_done();
        ack_is(16);
        @(posedge aclk); cpu.in_wait <= 1'b0;
        insn_end();
        check("wake_act", {31'h0, dbg_act}, 32'h1);
        send(SWD_K_INTR);
        repeat (2) @(posedge aclk);
        check("intr_exec", n_start, 2);
        pulse_done();
        ack_is(16);
        // Abort a command that never finishes
        send(SWD_K_NONI);
        i_host.abort_req();
        ack_is(128);
        check("abort", n_abort, 1);
        // A late finish of the cancelled command must not raise its acknowledge
        pulse_done();
        ack_is(0);
        // Second reset drops the handshake state
        do_reset();
        rd(`SWD_STAT_OFF, 32'h0, `SWD_RESP_OK);
        send(SWD_K_NONI);
        pulse_done();
        ack_is(0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
